// >>> hw/uar_responder.sv
`timescale 1ns/1ps
`default_nettype none
module uar_responder #(
  parameter int BIT_CYCLES = uar_pkg::BIT_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial line
  input wire logic serial_in_i,
  output logic serial_out_o,
  // events and interrupt
  output logic rx_done_event_o,
  output logic tx_done_event_o,
  output logic rx_error_event_o,
  output logic irq_o
);
  uar_link_if lk ();

  logic enable;
  logic [2:0] status;
  logic [2:0] mask;
  logic [2:0] events;
  uar_pkg::uar_state_type state;
  uar_pkg::uar_msg_type msg;
  uar_pkg::uar_msg_type next_msg;
  logic [1:0] idx;
  logic [7:0] last_char;
  logic [2:0] last_err;
  logic take;
  logic wb_req;
  logic wb_wr;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////
  // reply table
  function automatic logic [7:0] msg_byte(
    input uar_pkg::uar_msg_type m,
    input logic [1:0] i
  );
    logic [7:0] b;
    b = uar_pkg::CH_LF;
    if (i == 2'd2) begin
      b = uar_pkg::CH_CR;
    end else if (i == 2'd0) begin
      case (m)
        uar_pkg::MSG_OK_UP: b = uar_pkg::CH_O_UP;
        uar_pkg::MSG_OK_LO: b = uar_pkg::CH_O_LO;
        uar_pkg::MSG_UC: b = uar_pkg::CH_U_UP;
        uar_pkg::MSG_PE: b = uar_pkg::CH_P_UP;
        uar_pkg::MSG_FE: b = uar_pkg::CH_F_UP;
        uar_pkg::MSG_OE: b = uar_pkg::CH_O_UP;
        default: b = uar_pkg::CH_U_UP;
      endcase
    end else if (i == 2'd1) begin
      case (m)
        uar_pkg::MSG_OK_UP: b = uar_pkg::CH_K_UP;
        uar_pkg::MSG_OK_LO: b = uar_pkg::CH_K_LO;
        uar_pkg::MSG_UC: b = uar_pkg::CH_C_UP;
        default: b = uar_pkg::CH_E_UP;
      endcase
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////
  // line engines
  uar_rx #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .serial_in_i(serial_in_i),
    .lk(lk.rxm)
  );

  uar_tx #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_tx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lk(lk.txm)
  );

  assign serial_out_o = lk.tx_line;

  ////////////////////////////////////////////////////////////
  // classification: overrun outranks parity, parity outranks framing
  always_comb begin
    if (lk.rx_ovr) begin
      next_msg = uar_pkg::MSG_OE;
    end else if (lk.rx_perr) begin
      next_msg = uar_pkg::MSG_PE;
    end else if (lk.rx_ferr) begin
      next_msg = uar_pkg::MSG_FE;
    end else if (lk.rx_data == uar_pkg::CH_UPPER_T) begin
      next_msg = uar_pkg::MSG_OK_UP;
    end else if (lk.rx_data == uar_pkg::CH_LOWER_T) begin
      next_msg = uar_pkg::MSG_OK_LO;
    end else begin
      next_msg = uar_pkg::MSG_UC;
    end
  end

  // a character still pending after a reply is served next
  assign take = state == uar_pkg::ST_WAIT && enable && lk.rx_valid
    && !lk.rx_consume;

  ////////////////////////////////////////////////////////////
  // reply sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= uar_pkg::ST_WAIT;
      msg <= uar_pkg::MSG_UC;
      idx <= 2'd0;
      lk.tx_start <= 1'b0;
      lk.tx_data <= 8'h00;
      lk.rx_consume <= 1'b0;
    end else begin
      lk.rx_consume <= 1'b0;
      lk.tx_start <= 1'b0;
      case (state)
        uar_pkg::ST_WAIT: begin
          if (take) begin
            msg <= next_msg;
            idx <= 2'd0;
            lk.tx_data <= msg_byte(next_msg, 2'd0);
            lk.tx_start <= 1'b1;
            lk.rx_consume <= 1'b1;
            state <= uar_pkg::ST_SEND;
          end
        end
        uar_pkg::ST_SEND: begin
          // next byte launched the cycle after the stop bit ends
          if (lk.tx_done) begin
            if (idx == 2'd3) begin
              state <= uar_pkg::ST_WAIT;
            end else begin
              idx <= idx + 2'd1;
              lk.tx_data <= msg_byte(msg, idx + 2'd1);
              lk.tx_start <= 1'b1;
            end
          end
        end
        default: begin
          state <= uar_pkg::ST_WAIT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // last character seen, for software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_char <= 8'h00;
      last_err <= 3'h0;
    end else if (take) begin
      last_char <= lk.rx_data;
      last_err <= {lk.rx_ovr, lk.rx_ferr, lk.rx_perr};
    end
  end

  ////////////////////////////////////////////////////////////
  // event pulses
  assign events[uar_pkg::EV_RX_DONE] = lk.rx_frame && !lk.rx_bad;
  assign events[uar_pkg::EV_TX_DONE] = lk.tx_done;
  assign events[uar_pkg::EV_RX_ERR] = lk.rx_bad;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_done_event_o <= 1'b0;
      tx_done_event_o <= 1'b0;
      rx_error_event_o <= 1'b0;
    end else begin
      rx_done_event_o <= events[uar_pkg::EV_RX_DONE];
      tx_done_event_o <= events[uar_pkg::EV_TX_DONE];
      rx_error_event_o <= events[uar_pkg::EV_RX_ERR];
    end
  end

  ////////////////////////////////////////////////////////////
  // wishbone slave, one wait state
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr = wb_req && wb_ack_o && wb_we_i && wb_sel_i[0];

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      uar_pkg::ADDR_CTRL: rd_mux[uar_pkg::CTRL_ENABLE] = enable;
      uar_pkg::ADDR_STATUS: rd_mux[2:0] = status;
      uar_pkg::ADDR_MASK: rd_mux[2:0] = mask;
      uar_pkg::ADDR_RXINFO: begin
        rd_mux[7:0] = last_char;
        rd_mux[uar_pkg::RXI_ERR_LSB +: 3] = last_err;
        rd_mux[uar_pkg::RXI_BUSY] = state == uar_pkg::ST_SEND;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      if (wb_req && !wb_ack_o) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable <= uar_pkg::CTRL_RESET;
      mask <= uar_pkg::MASK_RESET;
    end else if (wb_wr) begin
      if (wb_adr_i == uar_pkg::ADDR_CTRL) begin
        enable <= wb_dat_i[uar_pkg::CTRL_ENABLE];
      end
      if (wb_adr_i == uar_pkg::ADDR_MASK) begin
        mask <= wb_dat_i[2:0];
      end
    end
  end

  // sticky status: a new event beats a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= 3'h0;
    end else if (wb_wr && wb_adr_i == uar_pkg::ADDR_STATUS) begin
      status <= (status & ~wb_dat_i[2:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end

  ////////////////////////////////////////////////////////////
  // checks
  sequence s_take(logic [7:0] c);
    take && !lk.rx_ovr && !lk.rx_perr && !lk.rx_ferr
      && lk.rx_data == c;
  endsequence

  sequence s_first(logic [7:0] b);
    lk.tx_start && lk.tx_data == b;
  endsequence

  property p_reply(logic [7:0] c, logic [7:0] b);
    @(posedge clk_i) disable iff (rst_i)
      s_take(c) |=> s_first(b);
  endproperty

  AST_REPLY_UPPER: assert property (
    p_reply(uar_pkg::CH_UPPER_T, uar_pkg::CH_O_UP))
    else $error("upper T not answered with O");

  AST_REPLY_LOWER: assert property (
    p_reply(uar_pkg::CH_LOWER_T, uar_pkg::CH_O_LO))
    else $error("lower t not answered with o");

  AST_REPLY_OTHER: assert property (@(posedge clk_i)
    disable iff (rst_i)
    take && !lk.rx_ovr && !lk.rx_perr && !lk.rx_ferr
      && lk.rx_data != uar_pkg::CH_UPPER_T
      && lk.rx_data != uar_pkg::CH_LOWER_T
      |=> s_first(uar_pkg::CH_U_UP) ##0 msg == uar_pkg::MSG_UC)
    else $error("other character not answered with U");

  AST_REPLY_PARITY: assert property (@(posedge clk_i)
    disable iff (rst_i)
    take && lk.rx_perr && !lk.rx_ovr |=> s_first(uar_pkg::CH_P_UP))
    else $error("parity error not answered with P");

  AST_REPLY_FRAMING: assert property (@(posedge clk_i)
    disable iff (rst_i)
    take && lk.rx_ferr && !lk.rx_perr && !lk.rx_ovr
      |=> s_first(uar_pkg::CH_F_UP))
    else $error("framing error not answered with F");

  AST_REPLY_OVERRUN: assert property (@(posedge clk_i)
    disable iff (rst_i)
    take && lk.rx_ovr |=> s_first(uar_pkg::CH_O_UP)
      ##0 msg == uar_pkg::MSG_OE)
    else $error("overrun not answered with O");

  AST_TAIL_CR: assert property (@(posedge clk_i)
    disable iff (rst_i)
    state == uar_pkg::ST_SEND && lk.tx_done && idx == 2'd1
      |=> s_first(uar_pkg::CH_CR) ##0 idx == 2'd2)
    else $error("third reply byte is not carriage return");

  AST_NO_NEW_REPLY: assert property (@(posedge clk_i)
    disable iff (rst_i)
    state == uar_pkg::ST_SEND && !lk.tx_done
      |=> !lk.tx_start && $stable(msg))
    else $error("reply started while another is sending");

  AST_RETURN_WAIT: assert property (@(posedge clk_i)
    disable iff (rst_i)
    state == uar_pkg::ST_SEND && lk.tx_done && idx == 2'd3
      |=> state == uar_pkg::ST_WAIT && !lk.tx_start)
    else $error("no return to wait after last byte");

  AST_IDLE_QUIET: assert property (@(posedge clk_i)
    disable iff (rst_i)
    state == uar_pkg::ST_WAIT && !take |=> !lk.tx_start)
    else $error("transmit started without an event");

  AST_IRQ_LEVEL: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ##1 irq_o == |($past(status) & $past(mask)))
    else $error("interrupt does not follow masked status");

  AST_ERR_EVENT: assert property (@(posedge clk_i)
    disable iff (rst_i)
    lk.rx_frame && lk.rx_bad |=> rx_error_event_o
      && !rx_done_event_o ##1 !rx_error_event_o)
    else $error("error event not raised for one cycle");
endmodule
`default_nettype wire

// >>> pkg/uar_pkg.sv
`default_nettype none
package uar_pkg;
  // link timing
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_BPS = 9600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
  localparam int FRAME_BITS = 11;
  localparam int DATA_BITS = 8;
  // received characters that are recognised
  localparam logic [7:0] CH_UPPER_T = 8'h54;
  localparam logic [7:0] CH_LOWER_T = 8'h74;
  // reply characters
  localparam logic [7:0] CH_O_UP = 8'h4F;
  localparam logic [7:0] CH_K_UP = 8'h4B;
  localparam logic [7:0] CH_O_LO = 8'h6F;
  localparam logic [7:0] CH_K_LO = 8'h6B;
  localparam logic [7:0] CH_U_UP = 8'h55;
  localparam logic [7:0] CH_C_UP = 8'h43;
  localparam logic [7:0] CH_P_UP = 8'h50;
  localparam logic [7:0] CH_F_UP = 8'h46;
  localparam logic [7:0] CH_E_UP = 8'h45;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  // register map, byte addresses
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_MASK = 5'h08;
  localparam logic [4:0] ADDR_RXINFO = 5'h0C;
  // field positions
  localparam int CTRL_ENABLE = 0;
  localparam int EV_RX_DONE = 0;
  localparam int EV_TX_DONE = 1;
  localparam int EV_RX_ERR = 2;
  localparam int RXI_ERR_LSB = 8;
  localparam int RXI_BUSY = 16;
  // reset values
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  typedef enum logic [2:0] {
    MSG_OK_UP = 3'b000,
    MSG_OK_LO = 3'b001,
    MSG_UC = 3'b010,
    MSG_PE = 3'b011,
    MSG_FE = 3'b100,
    MSG_OE = 3'b101
  } uar_msg_type;
  typedef enum logic [0:0] {
    ST_WAIT = 1'b0,
    ST_SEND = 1'b1
  } uar_state_type;
endpackage
`default_nettype wire

// >>> pkg/uar_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface uar_link_if;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_perr;
  logic rx_ferr;
  logic rx_ovr;
  logic rx_frame;
  logic rx_bad;
  logic rx_consume;
  logic [7:0] tx_data;
  logic tx_start;
  logic tx_busy;
  logic tx_done;
  logic tx_line;
  modport core (input rx_data, rx_valid, rx_perr, rx_ferr, rx_ovr,
    rx_frame, rx_bad, tx_busy, tx_done, tx_line,
    output rx_consume, tx_data, tx_start);
  modport rxm (output rx_data, rx_valid, rx_perr, rx_ferr, rx_ovr,
    rx_frame, rx_bad, input rx_consume);
  modport txm (input tx_data, tx_start,
    output tx_busy, tx_done, tx_line);
endinterface
`default_nettype wire

// >>> hw/uar_rx.sv
`timescale 1ns/1ps
`default_nettype none
module uar_rx #(
  parameter int BIT_CYCLES = uar_pkg::BIT_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // line and link
  input wire logic serial_in_i,
  uar_link_if.rxm lk
);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  logic busy;
  logic [CW-1:0] cnt;
  logic [3:0] bitn;
  logic [7:0] sh;
  logic par;
  logic done;
  // line read as is, idle high
  assign done = busy && cnt == '0 && bitn == 4'hA;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      cnt <= '0;
      bitn <= 4'h0;
      sh <= 8'h00;
      par <= 1'b0;
    end else if (!busy) begin
      // sample mid-bit from here on
      if (!serial_in_i) begin
        busy <= 1'b1;
        cnt <= CW'(BIT_CYCLES / 2);
        bitn <= 4'h0;
      end
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end else begin
      cnt <= CW'(BIT_CYCLES - 1);
      bitn <= bitn + 4'h1;
      if (bitn == 4'h0 && serial_in_i) begin
        busy <= 1'b0;
      end
      if (bitn >= 4'h1 && bitn <= 4'h8) begin
        sh <= {serial_in_i, sh[7:1]};
      end
      if (bitn == 4'h9) begin
        par <= serial_in_i;
      end
      if (bitn == 4'hA) begin
        busy <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lk.rx_valid <= 1'b0;
      lk.rx_data <= 8'h00;
      lk.rx_perr <= 1'b0;
      lk.rx_ferr <= 1'b0;
      lk.rx_ovr <= 1'b0;
      lk.rx_frame <= 1'b0;
      lk.rx_bad <= 1'b0;
    end else begin
      lk.rx_frame <= done;
      // same overrun test as the flag below, so the event agrees with it
      lk.rx_bad <= done && (^{sh, par} || !serial_in_i
        || (lk.rx_valid && !lk.rx_consume));
      // a frame landing with the consume still counts
      if (done) begin
        lk.rx_valid <= 1'b1;
        lk.rx_data <= sh;
        lk.rx_perr <= ^{sh, par};
        lk.rx_ferr <= !serial_in_i;
        lk.rx_ovr <= lk.rx_valid && !lk.rx_consume;
      end else if (lk.rx_consume) begin
        lk.rx_valid <= 1'b0;
        lk.rx_ovr <= 1'b0;
      end
    end
  end
  AST_PARITY: assert property (@(posedge clk_i) disable iff (rst_i)
    done |=> lk.rx_perr == $past(^{sh, par}))
    else $error("parity flag does not match frame");
endmodule
`default_nettype wire

// >>> hw/uar_tx.sv
`timescale 1ns/1ps
`default_nettype none
module uar_tx #(
  parameter int BIT_CYCLES = uar_pkg::BIT_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link
  uar_link_if.txm lk
);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  logic [CW-1:0] cnt;
  logic [3:0] left;
  logic [10:0] sh;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lk.tx_busy <= 1'b0;
      lk.tx_done <= 1'b0;
      lk.tx_line <= 1'b1;
      cnt <= '0;
      left <= 4'h0;
      sh <= '1;
    end else begin
      lk.tx_done <= 1'b0;
      if (!lk.tx_busy) begin
        lk.tx_line <= 1'b1;
        if (lk.tx_start) begin
          // stop, even parity, data lsb first, start
          sh <= {1'b1, ^lk.tx_data, lk.tx_data, 1'b0};
          lk.tx_busy <= 1'b1;
          left <= 4'(uar_pkg::FRAME_BITS);
          cnt <= '0;
        end
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
      end else if (left == 4'h0) begin
        lk.tx_busy <= 1'b0;
        lk.tx_done <= 1'b1;
      end else begin
        lk.tx_line <= sh[0];
        sh <= {1'b1, sh[10:1]};
        left <= left - 4'h1;
        cnt <= CW'(BIT_CYCLES - 1);
      end
    end
  end
  AST_START_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    !lk.tx_busy && lk.tx_start |=> ##1 !lk.tx_line)
    else $error("frame did not open with a low start bit");
endmodule
`default_nettype wire

// >>> test/uar_station.sv
`timescale 1ns/1ps
`default_nettype none
module uar_station #(
  parameter int BIT_CYCLES = 16
) (
  // clock
  input wire logic clk_i,
  // serial lines, seen from the station
  input wire logic line_i,
  output logic line_o
);
  logic [10:0] rx_q[$];

  initial line_o = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] d, input logic bad_par,
    input logic bad_stop);
    logic [10:0] f;
    f = {1'b1, (^d) ^ bad_par, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o <= f[i];
      repeat (BIT_CYCLES) @(posedge clk_i);
    end
    // short low stop: the restart it causes ends as a false start
    line_o <= ~bad_stop;
    repeat (BIT_CYCLES / 2 + 3) @(posedge clk_i);
    line_o <= 1'b1;
    repeat (BIT_CYCLES / 2 - 3) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // reply capture, mid-bit sampling
  always begin
    logic [10:0] f;
    @(negedge line_i);
    repeat (BIT_CYCLES / 2) @(posedge clk_i);
    for (int i = 0; i < 11; i++) begin
      f[i] = line_i;
      if (i < 10) repeat (BIT_CYCLES) @(posedge clk_i);
    end
    rx_q.push_back(f);
  end
endmodule
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  error_cnt++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  localparam int B = 16;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [4:0] wb_adr = 5'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_q;
  logic wb_ack, line_in, line_out, ev_rxd, ev_txd, ev_err, irq;
  int error_cnt = 0;
  int tests_run = 0;
  int n_rxd = 0, n_txd = 0, n_err = 0, x_rxd = 0, x_txd = 0, x_err = 0;
  integer seed = 32'h1d1fbb0e;
  logic [7:0] ch;

  always #5 clk_i = ~clk_i;

  uar_responder #(.BIT_CYCLES(B)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .serial_in_i(line_in),
    .serial_out_o(line_out), .rx_done_event_o(ev_rxd),
    .tx_done_event_o(ev_txd), .rx_error_event_o(ev_err), .irq_o(irq));

  uar_station #(.BIT_CYCLES(B)) st (.clk_i(clk_i), .line_i(line_out),
    .line_o(line_in));

  always @(posedge clk_i) begin
    n_rxd <= rst_i ? 0 : n_rxd + int'(ev_rxd);
    n_txd <= rst_i ? 0 : n_txd + int'(ev_txd);
    n_err <= rst_i ? 0 : n_err + int'(ev_err);
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wb(input logic we, input logic [4:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    `CHK("wb ack", 1'b1, wb_ack)
    q = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] m,
    input logic [31:0] ex);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    `CHK("register", ex, q & m)
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask

  // four reply bytes, first byte in the top lane
  function automatic logic [31:0] reply(input logic [7:0] c, input int k);
    logic [15:0] h;
    case (k)
      1: h = 16'h5045;
      2: h = 16'h4645;
      3: h = 16'h4F45;
      default: h = (c == 8'h54) ? 16'h4F4B
        : (c == 8'h74) ? 16'h6F6B : 16'h5543;
    endcase
    return {h, 16'h0D0A};
  endfunction

  task automatic expect_reply(input logic [31:0] r);
    int n;
    logic [10:0] f;
    n = 0;
    while (st.rx_q.size() < 4 && n < 1500) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("reply bytes", 1'b1, st.rx_q.size() >= 4)
    if (st.rx_q.size() < 4) return;
    for (int i = 0; i < 4; i++) begin
      f = st.rx_q.pop_front();
      `CHK("start bit", 1'b0, f[0])
      `CHK("reply byte", r[31 - 8 * i -: 8], f[8:1])
      `CHK("parity", 1'b0, ^f[9:1])
      `CHK("stop bit", 1'b1, f[10])
    end
    repeat (2 * B) @(posedge clk_i);
    `CHK("extra bytes", 0, st.rx_q.size())
    `CHK("idle line", 1'b1, line_out)
  endtask

  // kind: 0 clean, 1 parity error, 2 framing error
  task automatic one_char(input logic [7:0] c, input int k);
    st.send(c, k == 1, k == 2);
    x_txd += 4;
    if (k == 0) x_rxd++;
    else x_err++;
    expect_reply(reply(c, k));
    `CHK("rx done count", x_rxd, n_rxd)
    `CHK("tx done count", x_txd, n_txd)
    `CHK("rx err count", x_err, n_err)
    if (k == 0) rd_chk(uar_pkg::ADDR_RXINFO, 32'h1_07FF, {24'h0, c});
    else rd_chk(uar_pkg::ADDR_RXINFO, 32'h1_0700,
      {21'h0, 3'(k), 8'h0});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk_i);
    error_cnt++;
    close_out();
  end

  initial begin
    logic [31:0] q;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("line after reset", 1'b1, line_out)
    `CHK("irq after reset", 1'b0, irq)
    for (int a = 0; a < 20; a += 4) rd_chk(5'(a), 32'hFFFF_FFFF, 32'h0);
    wb(1'b1, uar_pkg::ADDR_CTRL, 32'h1, 4'hE, q);
    rd_chk(uar_pkg::ADDR_CTRL, 32'hFFFF_FFFF, 32'h0);
    wr(uar_pkg::ADDR_MASK, 32'h7);
    wr(uar_pkg::ADDR_CTRL, 32'h1);
    for (int k = 0; k < 6; k++) begin
      ch = (k == 0) ? 8'h54 : (k == 1) ? 8'h74
        : (k == 2) ? 8'hFF : 8'($random(seed));
      if (k == 3 && (ch == 8'h54 || ch == 8'h74)) ch = 8'h00;
      one_char(ch, (k < 4) ? 0 : k - 3);
    end
    // interrupt: sticky status, mask and clear
    rd_chk(uar_pkg::ADDR_STATUS, 32'h7, 32'h7);
    `CHK("irq unmasked", 1'b1, irq)
    wr(uar_pkg::ADDR_STATUS, 32'h7);
    repeat (2) @(posedge clk_i);
    rd_chk(uar_pkg::ADDR_STATUS, 32'h7, 32'h0);
    `CHK("irq cleared", 1'b0, irq)
    wr(uar_pkg::ADDR_MASK, 32'h4);
    one_char(8'h61, 0);
    rd_chk(uar_pkg::ADDR_STATUS, 32'h7, 32'h3);
    `CHK("irq masked", 1'b0, irq)
    wr(uar_pkg::ADDR_MASK, 32'h1);
    repeat (2) @(posedge clk_i);
    `CHK("irq rx done", 1'b1, irq)
    wr(uar_pkg::ADDR_STATUS, 32'h7);
    repeat (2) @(posedge clk_i);
    `CHK("irq off", 1'b0, irq)
    // third char lands while the first reply sends and one waits
    x_err = n_err + 1;
    st.send(8'h54, 1'b0, 1'b0);
    st.send(8'h41, 1'b0, 1'b0);
    st.send(8'h42, 1'b0, 1'b0);
    expect_reply(reply(8'h54, 0));
    expect_reply(reply(8'h00, 3));
    `CHK("overrun event", x_err, n_err)
    rd_chk(uar_pkg::ADDR_RXINFO, 32'h1_0400, 32'h400);
    close_out();
  end
endmodule
`default_nettype wire
